// ### rtl/phfm_pkg.sv
// package: constants, register map and types of the ppp framing mapper
package phfm_pkg;

  // =========================================================
  // register map (byte addresses)
  localparam logic [11:0] ADDR_CTRL   = 12'h000;
  localparam logic [11:0] ADDR_MAP    = 12'h004;
  localparam logic [11:0] ADDR_USER   = 12'h008;
  localparam logic [11:0] ADDR_STATUS = 12'h00c;

  // =========================================================
  // field positions
  localparam int CTRL_HDLC_BIT = 0;
  localparam int CTRL_MODE_LSB = 1;
  localparam int CTRL_MODE_MSB = 2;
  localparam int CTRL_FILL_BIT = 3;
  localparam int CTRL_WIDE_BIT = 4;
  localparam int STAT_TX_BUSY  = 0;
  localparam int STAT_IN_FRAME = 1;
  localparam int STAT_CRC_OK   = 2;
  localparam int STAT_ABORT    = 3;
  localparam int STAT_DISCARD  = 4;

  // =========================================================
  // reset values
  localparam logic [4:0]  CTRL_RST = 5'h00;
  localparam logic [31:0] MAP_RST  = 32'h0000_0000;
  localparam logic [31:0] USER_RST = 32'h0000_0000;

  // =========================================================
  // octets and crc
  localparam logic [7:0]  OCT_FLAG   = 8'h7e;
  localparam logic [7:0]  OCT_ESC    = 8'h7d;
  localparam logic [7:0]  OCT_ONES   = 8'hff;
  localparam logic [7:0]  ESC_FLIP   = 8'h20;
  localparam logic [7:0]  CTRL_LIMIT = 8'h20;
  localparam logic [31:0] CRC16_POLY = 32'h0000_8408;
  localparam logic [31:0] CRC32_POLY = 32'hedb8_8320;
  localparam logic [15:0] CRC16_GOOD = 16'hf0b8;
  localparam logic [31:0] CRC32_GOOD = 32'hdebb_20e3;
  localparam logic [1:0]  CRC16_LAST = 2'h1;
  localparam logic [1:0]  CRC32_LAST = 2'h3;

  // =========================================================
  // line timing and abort lengths
  localparam int CLK_NS        = 10;
  localparam int TX_BIT_NS     = 160;
  localparam int TX_BIT_CYCLES = (TX_BIT_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0] ABORT_PPP  = 4'hf;
  localparam logic [3:0] ABORT_HDLC = 4'h7;
  localparam logic [2:0] STUFF_ONES = 3'h5;

  typedef enum logic [1:0] {
    MODE_OFF   = 2'b00,
    MODE_BIT   = 2'b01,
    MODE_OCT   = 2'b10,
    MODE_ASYNC = 2'b11
  } phfm_mode_t;

  typedef enum logic [2:0] {
    T_IDLE   = 3'b000,
    T_OPEN   = 3'b001,
    T_DATA   = 3'b010,
    T_CRC    = 3'b011,
    T_CLOSE  = 3'b100,
    T_ABORT1 = 3'b101,
    T_ABORT2 = 3'b110
  } phfm_tx_state_t;

endpackage : phfm_pkg

// ### rtl/phfm_crc_if.sv
// interface: crc engine request and result
`timescale 1ns/1ps
`default_nettype none
interface phfm_crc_if;
  logic        init;
  logic        en;
  logic        wide;
  logic [7:0]  data;
  logic [31:0] crc;
  logic        good;
  modport engine (input init, en, wide, data, output crc, good);
  modport user   (output init, en, wide, data, input crc, good);
endinterface : phfm_crc_if
`default_nettype wire

// ### rtl/phfm_crc.sv
// module: byte-wide reflected crc-16 / crc-32 engine
`timescale 1ns/1ps
`default_nettype none
module phfm_crc
  import phfm_pkg::*;
(
  // clock and reset
  input  wire logic  pclk,
  input  wire logic  presetn,
  // request and result
  phfm_crc_if.engine cif
);

  function automatic logic [31:0] phfm_crc_step(input logic [31:0] c, input logic [7:0] d,
                                                input logic wide);
    logic [31:0] r;
    logic        fb;
    r = c;
    for (int i = 0; i < 8; i++) begin
      fb = r[0] ^ d[i];
      r  = {1'b0, r[31:1]};
      if (fb) r = r ^ (wide ? CRC32_POLY : CRC16_POLY);
    end
    if (!wide) r[31:16] = 16'h0000;
    return r;
  endfunction : phfm_crc_step

  logic [31:0] crc;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) crc <= 32'hffff_ffff;
    else if (cif.init) crc <= cif.wide ? 32'hffff_ffff : 32'h0000_ffff;
    else if (cif.en) crc <= phfm_crc_step(crc, cif.data, cif.wide);
  end

  assign cif.crc  = crc;
  assign cif.good = cif.wide ? (crc == CRC32_GOOD) : (crc[15:0] == CRC16_GOOD);

endmodule : phfm_crc
`default_nettype wire

// ### rtl/phfm_esc.sv
// module: decides whether an octet must travel escaped
`timescale 1ns/1ps
`default_nettype none
module phfm_esc
  import phfm_pkg::*;
(
  // octet under test
  input  wire logic [7:0]  octet,
  // escape configuration
  input  wire logic [31:0] esc_map,
  input  wire logic [31:0] user_vals,
  // decision
  output logic             need
);

  always_comb begin
    need = 1'b0;
    if (octet == OCT_ESC || octet == OCT_FLAG) begin
      need = 1'b1;
    end else if (octet < CTRL_LIMIT) begin
      need = esc_map[octet[4:0]];
    end
    if (!need) begin
      for (int i = 0; i < 4; i++) begin
        if (user_vals[i*8 +: 8] == octet) need = 1'b1;
      end
    end
  end

endmodule : phfm_esc
`default_nettype wire

// ### rtl/phfm_top.sv
// module: ppp submodes of the hdlc channel with apb register access
//
// Chosen here: the APB slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module phfm_top
  import phfm_pkg::*;
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // transmit stream from the transmit fifo
  input  wire logic [7:0]  tx_data,
  input  wire logic        tx_valid,
  input  wire logic        tx_last,
  input  wire logic        tx_abort,
  output logic             tx_ready,
  // receive stream to the receive fifo
  output logic      [7:0]  rx_data,
  output logic             rx_valid,
  output logic             rx_end,
  output logic             rx_crc_ok,
  output logic             rx_abort,
  // serial line
  output logic             txd,
  output logic             txc,
  input  wire logic        rxc,
  input  wire logic        rxd,
  input  wire logic        rx_octet_sync
);

  // =========================================================
  // registers
  logic [4:0]  ctrl;
  logic [31:0] esc_map;
  logic [31:0] user_vals;
  logic        crc_ok_last;
  logic        abort_seen;
  logic        discard_seen;
  logic        in_frame;
  phfm_tx_state_t tx_st;

  wire logic       hdlc_en  = ctrl[CTRL_HDLC_BIT];
  wire phfm_mode_t mode     = phfm_mode_t'(ctrl[CTRL_MODE_MSB:CTRL_MODE_LSB]);
  wire logic       fill_sel = ctrl[CTRL_FILL_BIT];
  wire logic       wide     = ctrl[CTRL_WIDE_BIT];
  // escaping belongs to the octet-oriented submodes only
  wire logic esc_mode   = hdlc_en & (mode == MODE_OCT || mode == MODE_ASYNC);
  wire logic stuff_mode = hdlc_en & (mode == MODE_OFF || mode == MODE_BIT);

  function automatic logic phfm_addr_ok(input logic [11:0] a);
    return a == ADDR_CTRL || a == ADDR_MAP || a == ADDR_USER || a == ADDR_STATUS;
  endfunction : phfm_addr_ok

  wire logic apb_wr = psel & penable & pwrite & phfm_addr_ok(paddr);
  wire logic stat_clr = apb_wr & (paddr == ADDR_STATUS);
  logic [31:0] status;

  assign status  = {27'h0, discard_seen, abort_seen, crc_ok_last, in_frame, tx_st != T_IDLE};
  assign pready  = 1'b1;
  assign pslverr = psel & penable & !phfm_addr_ok(paddr);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl      <= CTRL_RST;
      esc_map   <= MAP_RST;
      user_vals <= USER_RST;
    end else if (apb_wr) begin
      if (paddr == ADDR_CTRL) ctrl <= pwdata[4:0];
      if (paddr == ADDR_MAP)  esc_map <= pwdata;
      if (paddr == ADDR_USER) user_vals <= pwdata;
    end
  end

  // read data is captured in the setup cycle so the access needs no wait
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) prdata <= 32'h0000_0000;
    else if (psel & !penable & !pwrite) begin
      case (paddr)
        ADDR_CTRL:   prdata <= {27'h0, ctrl};
        ADDR_MAP:    prdata <= esc_map;
        ADDR_USER:   prdata <= user_vals;
        ADDR_STATUS: prdata <= status;
        default:     prdata <= 32'h0000_0000;
      endcase
    end
  end

  // =========================================================
  // crc engines and escape deciders
  phfm_crc_if tcrc ();
  phfm_crc_if rcrc ();
  phfm_crc u_tx_crc (.pclk(pclk), .presetn(presetn), .cif(tcrc));
  phfm_crc u_rx_crc (.pclk(pclk), .presetn(presetn), .cif(rcrc));

  logic [7:0] tx_src;
  logic [7:0] rx_oct;
  logic       tx_need;
  logic       rx_need;
  phfm_esc u_tx_esc (.octet(tx_src), .esc_map(esc_map), .user_vals(user_vals), .need(tx_need));
  phfm_esc u_rx_esc (.octet(rx_oct), .esc_map(esc_map), .user_vals(user_vals), .need(rx_need));

  // =========================================================
  // transmit bit clock
  logic [4:0] bit_cnt;
  wire logic  tick = (bit_cnt == 5'(TX_BIT_CYCLES - 1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) bit_cnt <= 5'h00;
    else if (tick) bit_cnt <= 5'h00;
    else bit_cnt <= bit_cnt + 5'h01;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) txc <= 1'b0;
    else txc <= (bit_cnt < 5'(TX_BIT_CYCLES / 2));
  end

  // =========================================================
  // transmit octet sequencer
  logic       esc_pend;
  logic       abort_req;
  logic [1:0] crc_idx;
  logic       ser_take;
  logic [7:0] cur_oct;
  logic       cur_raw;
  logic [31:0] fcs;

  assign fcs = ~tcrc.crc >> {crc_idx, 3'b000};
  assign tx_src = (tx_st == T_CRC) ? fcs[7:0] : tx_data;
  wire logic esc_first = esc_mode & tx_need & !esc_pend;
  wire logic in_body   = (tx_st == T_DATA) || (tx_st == T_CRC);
  wire logic go_abort  = abort_req || (tx_st == T_DATA && !tx_valid);
  wire logic [1:0] crc_last = wide ? CRC32_LAST : CRC16_LAST;

  always_comb begin
    cur_oct = OCT_FLAG;
    cur_raw = 1'b1;
    case (tx_st)
      T_IDLE:   cur_oct = fill_sel ? OCT_FLAG : OCT_ONES;
      T_OPEN:   cur_oct = OCT_FLAG;
      T_CLOSE:  cur_oct = OCT_FLAG;
      T_DATA, T_CRC: begin
        cur_raw = 1'b0;
        if (esc_mode & esc_pend) cur_oct = tx_src ^ ESC_FLIP;
        else if (esc_first) cur_oct = OCT_ESC;
        else cur_oct = tx_src;
      end
      T_ABORT1: cur_oct = esc_mode ? OCT_ESC : OCT_ONES;
      T_ABORT2: cur_oct = esc_mode ? OCT_FLAG : OCT_ONES;
      default:  cur_oct = OCT_FLAG;
    endcase
  end

  assign tx_ready = ser_take & (tx_st == T_DATA) & tx_valid & !abort_req & !esc_first;
  assign tcrc.init = ser_take & (tx_st == T_OPEN);
  assign tcrc.en   = tx_ready;
  assign tcrc.wide = wide;
  assign tcrc.data = tx_data;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_st    <= T_IDLE;
      esc_pend <= 1'b0;
      crc_idx  <= 2'h0;
    end else if (ser_take) begin
      case (tx_st)
        T_IDLE:  if (hdlc_en & tx_valid) tx_st <= T_OPEN;
        T_OPEN:  tx_st <= T_DATA;
        T_DATA, T_CRC: begin
          if (go_abort) begin
            tx_st    <= T_ABORT1;
            esc_pend <= 1'b0;
          end else if (esc_first) begin
            esc_pend <= 1'b1;
          end else begin
            esc_pend <= 1'b0;
            if (tx_st == T_DATA && tx_last) begin
              tx_st   <= T_CRC;
              crc_idx <= 2'h0;
            end else if (tx_st == T_CRC) begin
              crc_idx <= crc_idx + 2'h1;
              if (crc_idx == crc_last) tx_st <= T_CLOSE;
            end
          end
        end
        T_CLOSE:  tx_st <= T_IDLE;
        // plain hdlc needs only eight ones, ppp bit-sync needs sixteen
        T_ABORT1: tx_st <= (stuff_mode && mode == MODE_OFF) ? T_IDLE : T_ABORT2;
        T_ABORT2: tx_st <= T_IDLE;
        default:  tx_st <= T_IDLE;
      endcase
    end
  end

  // a request is held until the next octet boundary only while in data or crc; outside them it is dropped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) abort_req <= 1'b0;
    else abort_req <= tx_abort | (abort_req & in_body & !ser_take);
  end

  // =========================================================
  // transmit serializer
  logic [9:0] sh;
  logic [3:0] left;
  logic [2:0] ones;
  logic [9:0] wsh;
  logic [3:0] wleft;
  logic       wraw;
  logic       raw_s;
  wire logic  ld    = (left == 4'h0);
  wire logic  stuff = stuff_mode & (ones == STUFF_ONES);

  assign ser_take = tick & ld;

  always_comb begin
    wsh   = sh;
    wleft = left;
    wraw  = raw_s;
    if (ld) begin
      wraw = cur_raw;
      if (hdlc_en && mode == MODE_ASYNC) begin
        wsh   = {1'b1, cur_oct, 1'b0};
        wleft = 4'ha;
      end else begin
        wsh   = {2'b11, cur_oct};
        wleft = 4'h8;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sh    <= 10'h3ff;
      left  <= 4'h0;
      raw_s <= 1'b1;
      ones  <= 3'h0;
      txd   <= 1'b1;
    end else if (tick) begin
      raw_s <= wraw;
      if (stuff) begin
        sh    <= wsh;
        left  <= wleft;
        ones  <= 3'h0;
        txd   <= 1'b0;
      end else begin
        sh    <= {1'b1, wsh[9:1]};
        left  <= wleft - 4'h1;
        // flags and aborts never count toward stuffing
        ones  <= (wraw | !wsh[0]) ? 3'h0 : ones + 3'h1;
        txd   <= hdlc_en ? wsh[0] : 1'b1;
      end
    end
  end

  // =========================================================
  // receive pin synchronisers
  logic rxc_m, rxc_s, rxc_d;
  logic rxd_m, rxd_s;
  logic rsy_m, rsy_s;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {rxc_m, rxc_s, rxc_d} <= 3'h0;
      {rxd_m, rxd_s}        <= 2'h3;
      {rsy_m, rsy_s}        <= 2'h0;
    end else begin
      {rxc_m, rxc_s, rxc_d} <= {rxc, rxc_m, rxc_s};
      {rxd_m, rxd_s}        <= {rxd, rxd_m};
      {rsy_m, rsy_s}        <= {rx_octet_sync, rsy_m};
    end
  end

  wire logic edge_rx = rxc_s & !rxc_d;

  // =========================================================
  // receive bit layer
  logic [7:0] rraw, dsh, next_raw, next_dsh;
  logic [3:0] rones, next_ones, dcnt, next_dcnt;
  logic       a_busy, next_abusy;
  logic       b_oct, b_flag, b_abort;
  wire logic [3:0] abort_lim = (mode == MODE_BIT) ? ABORT_PPP : ABORT_HDLC;

  always_comb begin
    b_oct      = 1'b0;
    b_flag     = 1'b0;
    b_abort    = 1'b0;
    rx_oct     = dsh;
    next_raw   = {rxd_s, rraw[7:1]};
    next_ones  = rxd_s ? ((rones == 4'hf) ? rones : rones + 4'h1) : 4'h0;
    next_dsh   = dsh;
    next_dcnt  = dcnt;
    next_abusy = a_busy;
    case (mode)
      MODE_OCT: begin
        next_dsh  = {rxd_s, dsh[7:1]};
        next_dcnt = (rsy_s || dcnt == 4'h8) ? 4'h1 : dcnt + 4'h1;
        b_oct     = (next_dcnt == 4'h8);
        rx_oct    = next_dsh;
      end
      MODE_ASYNC: begin
        if (!a_busy) begin
          next_abusy = !rxd_s;
          next_dcnt  = 4'h0;
        end else if (dcnt == 4'h8) begin
          next_abusy = 1'b0;
          b_oct      = rxd_s;
        end else begin
          next_dsh  = {rxd_s, dsh[7:1]};
          next_dcnt = dcnt + 4'h1;
        end
      end
      default: begin
        if (next_raw == OCT_FLAG) begin
          b_flag    = 1'b1;
          next_dcnt = 4'h0;
        end else if (next_ones == abort_lim) begin
          b_abort = 1'b1;
        end else if (!(!rxd_s && rones == 4'h5)) begin
          next_dsh  = {rxd_s, dsh[7:1]};
          next_dcnt = (dcnt == 4'h8) ? 4'h1 : dcnt + 4'h1;
          b_oct     = (next_dcnt == 4'h8);
          rx_oct    = next_dsh;
        end
      end
    endcase
    if (!edge_rx || !hdlc_en) begin
      b_oct   = 1'b0;
      b_flag  = 1'b0;
      b_abort = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rraw   <= 8'h00;
      rones  <= 4'h0;
      dsh    <= 8'h00;
      dcnt   <= 4'h0;
      a_busy <= 1'b0;
    end else if (edge_rx) begin
      rraw   <= next_raw;
      rones  <= next_ones;
      dsh    <= next_dsh;
      dcnt   <= next_dcnt;
      a_busy <= next_abusy;
    end
  end

  // =========================================================
  // receive octet layer: unescaping
  logic       esc_seen;
  logic       f_data, f_flag, f_abort, f_disc;
  logic [7:0] f_val;

  always_comb begin
    f_data  = 1'b0;
    f_flag  = 1'b0;
    f_abort = 1'b0;
    f_disc  = 1'b0;
    f_val   = rx_oct;
    if (esc_mode) begin
      if (b_oct) begin
        if (rx_oct == OCT_FLAG) begin
          f_abort = esc_seen;
          f_flag  = !esc_seen;
        end else if (esc_seen) begin
          f_data = 1'b1;
          f_val  = rx_oct ^ ESC_FLIP;
        end else if (rx_oct == OCT_ESC) begin
          f_data = 1'b0;
        end else if (rx_need) begin
          f_disc = 1'b1;
        end else begin
          f_data = 1'b1;
        end
      end
    end else begin
      f_data  = b_oct;
      f_flag  = b_flag;
      f_abort = b_abort;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) esc_seen <= 1'b0;
    else if (!esc_mode) esc_seen <= 1'b0;
    else if (b_oct) esc_seen <= !esc_seen && rx_oct == OCT_ESC;
  end

  // =========================================================
  // receive frame layer
  logic has_data;

  assign rcrc.init = f_flag;
  assign rcrc.en   = f_data & in_frame;
  assign rcrc.wide = wide;
  assign rcrc.data = f_val;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_frame  <= 1'b0;
      has_data  <= 1'b0;
      rx_data   <= 8'h00;
      rx_valid  <= 1'b0;
      rx_end    <= 1'b0;
      rx_crc_ok <= 1'b0;
      rx_abort  <= 1'b0;
    end else begin
      rx_valid <= f_data & in_frame;
      rx_end   <= f_flag & in_frame & has_data;
      rx_abort <= f_abort & in_frame;
      if (f_data & in_frame) begin
        rx_data  <= f_val;
        has_data <= 1'b1;
      end
      if (f_flag) begin
        if (in_frame & has_data) rx_crc_ok <= rcrc.good;
        in_frame <= 1'b1;
        has_data <= 1'b0;
      end
      if (f_abort || !hdlc_en) in_frame <= 1'b0;
    end
  end

  // =========================================================
  // status: sticky bits clear on write one, a new event wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      crc_ok_last  <= 1'b0;
      abort_seen   <= 1'b0;
      discard_seen <= 1'b0;
    end else begin
      if (f_flag & in_frame & has_data) crc_ok_last <= rcrc.good;
      abort_seen   <= (f_abort & in_frame) |
                      (abort_seen & !(stat_clr & pwdata[STAT_ABORT]));
      discard_seen <= f_disc | (discard_seen & !(stat_clr & pwdata[STAT_DISCARD]));
    end
  end

endmodule : phfm_top
`default_nettype wire

// ### testbench/phfm_checker.sv
// checker: port-level assertions for the ppp framing mapper
`timescale 1ns/1ps
`default_nettype none
module phfm_checker
  import phfm_pkg::*;
(
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // streams and line clock
  input wire logic        tx_valid,
  input wire logic        tx_ready,
  input wire logic        rx_valid,
  input wire logic        rx_end,
  input wire logic        rx_crc_ok,
  input wire logic        rx_abort,
  input wire logic        txc
);
  // ==========================================
  // address decode
  logic bad;
  assign bad = !(paddr inside {ADDR_CTRL, ADDR_MAP, ADDR_USER, ADDR_STATUS});
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  zero_wait_a: assert property (psel && penable |-> pready) else $error("pready low");
  bad_addr_a: assert property (psel && penable |-> pslverr == bad) else $error("pslverr");
  bad_read_a: assert property (psel && penable && !pwrite && bad |-> prdata == 32'h0)
    else $error("unmapped read data");
  bit_clock_a: assert property ($rose(txc) |=> $stable(txc)[*7] ##1 $fell(txc))
    else $error("txc high phase");
  take_valid_a: assert property (tx_ready |-> tx_valid) else $error("tx_ready without valid");
  octet_gap_a: assert property (tx_ready |=> !tx_ready[*8]) else $error("octets too close");
  rx_pulse_a: assert property (rx_valid |=> !rx_valid) else $error("rx_valid not a pulse");
  crc_update_a: assert property ($changed(rx_crc_ok) |-> rx_end)
    else $error("crc flag moved alone");
  abort_end_a: assert property (rx_abort |-> !rx_end)
    else $error("abort and end together");
endmodule : phfm_checker
bind phfm_top phfm_checker chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata,
  .pready, .pslverr, .tx_valid, .tx_ready, .rx_valid, .rx_end, .rx_crc_ok, .rx_abort, .txc);
`default_nettype wire

// ### testbench/phfm_peer.sv
// partner: remote ppp peer driving the receive line
`timescale 1ns/1ps
`default_nettype none
module phfm_peer
  import phfm_pkg::*;
(
  // clock
  input wire logic pclk,
  // line toward the device
  output logic     rxc,
  output logic     rxd,
  output logic     rx_octet_sync
);
  logic last;
  initial begin
    rxc = 1'b0;
    rxd = 1'b1;
    rx_octet_sync = 1'b0;
    last = 1'b1;
  end
  // rxc is 4 pclk low then 4 high, so the device sees it after its synchronizer
  task automatic put_bit(input logic b, input logic s);
    rxd <= b;
    rx_octet_sync <= s;
    last <= b;
    repeat (4) @(posedge pclk);
    rxc <= 1'b1;
    repeat (4) @(posedge pclk);
    rxc <= 1'b0;
  endtask : put_bit
  task automatic send(input logic [7:0] o, input logic a);
    if (a) put_bit(1'b0, 1'b0);
    for (int i = 0; i < 8; i++) put_bit(o[i], i == 0 && !a);
    if (a) put_bit(1'b1, 1'b0);
  endtask : send
  task automatic esc(input logic [7:0] o, input logic a);
    send(OCT_ESC, a);
    send(o ^ ESC_FLIP, a);
  endtask : esc
  // clock stands still between frames; the data line must not look held
  task automatic idle();
    rxd <= ~last;
    rx_octet_sync <= 1'b0;
  endtask : idle
endmodule : phfm_peer
`default_nettype wire

// ### testbench/testbench.sv
// testbench: self-checking bench of the ppp framing mapper
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import phfm_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, seen, seen_ab;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0] tx_data, rx_data, lastrx;
  logic tx_valid, tx_last, tx_abort, tx_ready, rx_valid, rx_end, rx_crc_ok, rx_abort;
  logic txd, txc, rxc, rxd, rx_octet_sync;
  logic [15:0] sh;
  int failures, cmp_count, nrx, nab, nend, k;
  typedef struct {logic [11:0] a; logic [31:0] d; logic [31:0] r; logic e;} phfm_row_t;
  phfm_row_t rows[4];
  phfm_top uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .tx_data, .tx_valid, .tx_last, .tx_abort, .tx_ready, .rx_data, .rx_valid, .rx_end,
    .rx_crc_ok, .rx_abort, .txd, .txc, .rxc, .rxd, .rx_octet_sync);
  phfm_peer peer (.pclk, .rxc, .rxd, .rx_octet_sync);
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // ==========================================
  // shared tasks
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : check
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : summarize
  // ==========================================
  // monitors
  always @(posedge pclk) begin
    if (rx_valid === 1'b1) begin
      nrx++;
      lastrx = rx_data;
    end
    if (rx_abort === 1'b1) nab++;
    if (rx_end === 1'b1) nend++;
  end
  always @(posedge txc) begin
    sh = {txd, sh[15:1]};
    if (sh === 16'h337d) seen = 1'b1;
    if (sh === 16'h7e7d) seen_ab = 1'b1;
  end
  initial begin
    repeat (60000) @(posedge pclk);
    failures++;
    summarize();
  end
  // ==========================================
  // main sequence
  initial begin
    {psel, penable, pwrite, tx_valid, tx_last, tx_abort, seen, seen_ab} = '0;
    {paddr, pwdata, tx_data, sh} = '0;
    presetn = 1'b0;
    rows = '{'{ADDR_CTRL, 32'h1d, 32'h1d, 1'b0}, '{ADDR_MAP, 32'ha5a5_0f0f, 32'ha5a5_0f0f, 1'b0},
             '{ADDR_USER, 32'h8877_6655, 32'h8877_6655, 1'b0}, '{12'h010, 32'h1, 32'h0, 1'b1}};
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    for (k = 0; k < 16; k += 4) begin
      apb(1'b0, k[11:0], 32'h0);
      check(rd, 32'h0);
    end
    $display("test done: reset values");
    foreach (rows[i]) begin
      apb(1'b1, rows[i].a, rows[i].d);
      apb(1'b0, rows[i].a, 32'h0);
      check(rd, rows[i].r);
      check(err, rows[i].e);
    end
    $display("test done: register rows");
    for (k = 0; k < 2; k++) begin
      apb(1'b1, ADDR_CTRL, k ? 32'h0f : 32'h0d);
      apb(1'b1, ADDR_MAP, 32'h0008_0000);
      apb(1'b1, ADDR_STATUS, 32'h18);
      nrx = 0;
      nab = 0;
      peer.send(OCT_FLAG, k[0]);
      peer.esc(8'h13, k[0]);
      peer.send(8'h13, k[0]);
      peer.esc(OCT_FLAG, k[0]);
      peer.send(OCT_ESC, k[0]);
      peer.send(OCT_FLAG, k[0]);
      peer.idle();
      repeat (20) @(posedge pclk);
      check(nrx, 2);
      check(lastrx, OCT_FLAG);
      check(nab, 1);
      apb(1'b0, ADDR_STATUS, 32'h0);
      check(rd[STAT_DISCARD], 1'b1);
      // clean frame carries the standard check fcs; the async pass corrupts it
      nend = 0;
      peer.send(OCT_FLAG, k[0]);
      for (int i = 1; i < 10; i++) peer.send(8'h30 + 8'(i), k[0]);
      peer.send(8'h6e, k[0]);
      peer.send(k[0] ? 8'h91 : 8'h90, k[0]);
      peer.send(OCT_FLAG, k[0]);
      repeat (20) @(posedge pclk);
      check(nend, 1);
      check(rx_crc_ok, !k[0]);
      $display("test done: escaped receive");
    end
    apb(1'b1, ADDR_CTRL, 32'h03);
    nab = 0;
    peer.send(OCT_FLAG, 1'b0);
    peer.send(8'h41, 1'b0);
    peer.send(OCT_ONES, 1'b0);
    peer.send(OCT_ONES, 1'b0);
    peer.idle();
    repeat (20) @(posedge pclk);
    check(nab, 1);
    $display("test done: long abort");
    apb(1'b1, ADDR_CTRL, 32'h0d);
    tx_data <= 8'h13;
    tx_valid <= 1'b1;
    tx_last <= 1'b1;
    k = 0;
    do begin
      @(negedge pclk);
      k++;
    end while (tx_ready !== 1'b1 && k < 3000);
    @(posedge pclk);
    tx_valid <= 1'b0;
    repeat (2000) @(posedge pclk);
    check(seen, 1'b1);
    tx_data <= 8'h41;
    tx_last <= 1'b0;
    tx_valid <= 1'b1;
    @(posedge tx_ready);
    @(posedge pclk);
    tx_valid <= 1'b0;
    tx_abort <= 1'b1;
    @(posedge pclk);
    tx_abort <= 1'b0;
    repeat (600) @(posedge pclk);
    check(seen_ab, 1'b1);
    apb(1'b1, ADDR_CTRL, 32'h04);
    tx_valid <= 1'b1;
    k = 0;
    repeat (400) @(negedge pclk) if (tx_ready === 1'b1) k++;
    check(k, 0);
    $display("test done: transmit");
    summarize();
  end
endmodule : testbench
`default_nettype wire
